// ### hw/typec_regs_pkg.sv
// constants for the type-c port control and event flag registers
package typec_regs_pkg;
   localparam logic [7:0] CTRL_ADDR       = 8'h02;
   localparam logic [7:0] FLAGS_ADDR      = 8'h03;
   localparam logic [7:0] CTRL_RESET      = 8'h00;
   localparam logic [7:0] FLAGS_RESET     = 8'h00;
   localparam logic [7:0] FLAGS_LATCHED   = 8'hEB; // bits 7,6,5,3,1,0
   localparam logic [7:0] FLAGS_WRITABLE  = 8'hFF;
   localparam int         CTRL_POWERSAVE  = 7;
   localparam int         CTRL_PREF_SINK  = 6;
   localparam int         CTRL_ACC_DET    = 5;
   localparam int         CTRL_CUR_LSB    = 3;
   localparam int         CTRL_ROLE_LSB   = 1;
   localparam int         CTRL_MASK       = 0;
   localparam int         FLAG_RECOVER    = 7;
   localparam int         FLAG_OCP        = 6;
   localparam int         FLAG_OVP        = 5;
   localparam int         FLAG_OTP        = 3;
   localparam int         FLAG_LIVE       = 2;
   localparam int         FLAG_DETACH     = 1;
   localparam int         FLAG_ATTACH     = 0;
   localparam int         NUM_EVENTS      = 6;
   localparam logic [1:0] ROLE_SINK       = 2'h0;
   localparam logic [1:0] ROLE_SOURCE     = 2'h1;
   localparam logic [1:0] ROLE_DUAL       = 2'h2;
   localparam logic [1:0] ROLE_DUAL_PREF  = 2'h3;
   localparam logic [1:0] CUR_DEFAULT     = 2'h0;
endpackage : typec_regs_pkg

// ### hw/sync_2ff.sv
// two flip-flop synchroniser for pin-level inputs
`timescale 1ns/100ps
`default_nettype none
module sync_2ff #(
   parameter int WIDTH = 1
) (
   input  wire logic             ref_clk_in,
   input  wire logic             sys_rst_in,
   input  wire logic             ce_in,
   input  wire logic [WIDTH-1:0] async_in,
   output var  logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_r;

   // first stage feeds only the second stage
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         meta_r   <= '0;
         sync_out <= '0;
      end else if (ce_in) begin
         meta_r   <= async_in;
         sync_out <= meta_r;
      end
   end
endmodule : sync_2ff
`default_nettype wire

// ### hw/typec_port_control_interrupt_regs.sv
// control and event flag registers of a type-c port controller
`timescale 1ns/100ps
`default_nettype none
module typec_port_control_interrupt_regs (
   input  wire logic       ref_clk_in,
   input  wire logic       sys_rst_in,
   input  wire logic       ce_in,
   // register port from the serial slave engine, same clock
   input  wire logic [7:0] reg_addr_in,
   input  wire logic       reg_wr_in,
   input  wire logic [7:0] reg_wdata_in,
   input  wire logic       reg_rd_in,
   input  wire logic       reg_rd_done_in,
   output var  logic [7:0] reg_rdata_out,
   // pins and analog event sources, asynchronous
   input  wire logic       chip_enable_n_in,
   input  wire logic [1:0] role_strap_in,
   input  wire logic       fault_recovered_in,
   input  wire logic       over_current_event_in,
   input  wire logic       over_voltage_event_in,
   input  wire logic       over_temp_event_in,
   input  wire logic       fault_live_in,
   input  wire logic       attached_in,
   input  wire logic       acting_as_sink_in,
   // settings to the detection logic
   output var  logic       low_power_out,
   output var  logic       outputs_hiz_out,
   output var  logic       cc_pulldown_out,
   output var  logic       prefer_source_attempt_out,
   output var  logic       prefer_sink_attempt_out,
   output var  logic       accessory_detect_en_out,
   output var  logic [1:0] source_current_out,
   output var  logic [1:0] port_role_out,
   // open-drain interrupt pin
   output var  logic       interrupt_request_n_out,
   output var  logic       interrupt_request_n_oe_n_out
);
   localparam int NSYNC = 10;
   // positions of the fault events inside the synchronised event bundle
   localparam int EV_RECOVER = 3;
   localparam int EV_OCP     = 2;
   localparam int EV_OVP     = 1;
   localparam int EV_OTP     = 0;
   localparam int NUM_FAULTS = 4;
   // synchroniser depth; pin values are not trusted until it has filled
   localparam logic [1:0] SYNC_FILL = 2'h2;

   typedef struct packed {
      // software-visible registers
      logic [7:0] ctrl;
      logic [7:0] flags;
      // bookkeeping for strap load, clear-on-read and edge detection
      logic       strap_done;
      logic       rd_pending;
      logic [1:0] settle;
      logic [3:0] ev_prev;
      logic       attached_prev;
      // registered copies of the module outputs
      logic [7:0] rdata;
      logic       low_power;
      logic       hiz;
      logic       cc_pd;
      logic       pref_src;
      logic       pref_snk;
      logic       acc_det;
      logic [1:0] cur;
      logic [1:0] role;
      logic       int_oe_n;
   } state_s;

   state_s           state_r;
   state_s           state_nxt;
   logic [NSYNC-1:0] pins_sync;

   logic       en_n_s;
   logic [1:0] strap_s;
   logic [3:0] ev_s;
   logic [3:0] ev_rise;
   logic       pins_ready;
   logic       live_s;
   logic       attached_s;
   logic       sink_s;

   // pin inputs pass two flops before use
   // nothing in this module reads the first stage
   sync_2ff #(.WIDTH(NSYNC)) u_pin_sync (
      .ref_clk_in (ref_clk_in),
      .sys_rst_in (sys_rst_in),
      .ce_in      (ce_in),
      .async_in   ({chip_enable_n_in, role_strap_in, fault_recovered_in, over_current_event_in,
                    over_voltage_event_in, over_temp_event_in, fault_live_in, attached_in,
                    acting_as_sink_in}),
      .sync_out   (pins_sync)
   );

   // unpack the synchronised pins
   assign {en_n_s, strap_s, ev_s, live_s, attached_s, sink_s} = pins_sync;

   // rising edge of each fault event against its previous sample
   for (genvar g = 0; g < NUM_FAULTS; g++) begin : g_fault_edge
      assign ev_rise[g] = ev_s[g] & ~state_r.ev_prev[g];
   end

   // synchroniser reset zeros would read as an enabled pin until it fills
   assign pins_ready = (state_r.settle == SYNC_FILL);

   // next-state logic for registers, events and pin outputs
   always_comb begin
      logic [7:0] set_bits;
      logic [7:0] ctrl_v;
      logic       any_ev;
      set_bits  = '0;
      ctrl_v    = state_r.ctrl;
      any_ev    = 1'b0;
      state_nxt = state_r;

      // register writes; only the control register is writable
      if (reg_wr_in && reg_addr_in == typec_regs_pkg::CTRL_ADDR) begin
         ctrl_v = reg_wdata_in;
      end

      // count the synchroniser fill after reset
      if (!pins_ready) begin
         state_nxt.settle = state_r.settle + 2'h1;
      end

      // one-shot strap load on the first enable after reset
      // gated by the fill count so no false enable follows reset
      if (!state_r.strap_done && pins_ready && !en_n_s) begin
         ctrl_v[typec_regs_pkg::CTRL_ROLE_LSB +: 2] = strap_s;
         state_nxt.strap_done = 1'b1;
      end
      state_nxt.ctrl = ctrl_v;

      // rising edges of fault events and both edges of attached set latched bits
      set_bits[typec_regs_pkg::FLAG_RECOVER] = ev_rise[EV_RECOVER];
      set_bits[typec_regs_pkg::FLAG_OCP]     = ev_rise[EV_OCP];
      set_bits[typec_regs_pkg::FLAG_OVP]     = ev_rise[EV_OVP];
      set_bits[typec_regs_pkg::FLAG_OTP]     = ev_rise[EV_OTP];
      set_bits[typec_regs_pkg::FLAG_DETACH]  = ~attached_s & state_r.attached_prev;
      set_bits[typec_regs_pkg::FLAG_ATTACH]  = attached_s & ~state_r.attached_prev;
      state_nxt.ev_prev       = ev_s;
      state_nxt.attached_prev = attached_s;

      // read capture; bit 2 is the live fault, not latched
      // the captured byte stands until the next read strobe
      if (reg_rd_in) begin
         case (reg_addr_in)
            typec_regs_pkg::CTRL_ADDR: begin
               state_nxt.rdata = state_r.ctrl;
            end
            typec_regs_pkg::FLAGS_ADDR: begin
               state_nxt.rdata = state_r.flags;
            end
            default: begin
               state_nxt.rdata = '0;
            end
         endcase
         state_nxt.rd_pending = (reg_addr_in == typec_regs_pkg::FLAGS_ADDR);
      end

      // clear on delivered read; a same-cycle event still sets
      // only a delivered flag byte clears, so a stray done pulse or a
      // control readback leaves pending events alone
      if (reg_rd_done_in && state_r.rd_pending) begin
         state_nxt.flags = (state_r.flags & ~typec_regs_pkg::FLAGS_LATCHED) | set_bits;
         state_nxt.rd_pending = 1'b0;
      end else begin
         state_nxt.flags = state_r.flags | set_bits;
      end
      state_nxt.flags[typec_regs_pkg::FLAG_LIVE] = live_s;

      // control outputs
      // recomputed every cycle so a change of sink state applies at once
      state_nxt.low_power = ctrl_v[typec_regs_pkg::CTRL_POWERSAVE];
      state_nxt.hiz       = ctrl_v[typec_regs_pkg::CTRL_POWERSAVE];
      state_nxt.cc_pd     = ctrl_v[typec_regs_pkg::CTRL_POWERSAVE];
      state_nxt.pref_snk  = ctrl_v[typec_regs_pkg::CTRL_PREF_SINK] &
                            (ctrl_v[typec_regs_pkg::CTRL_ROLE_LSB +: 2] == typec_regs_pkg::ROLE_DUAL_PREF);
      state_nxt.pref_src  = ~ctrl_v[typec_regs_pkg::CTRL_PREF_SINK] &
                            (ctrl_v[typec_regs_pkg::CTRL_ROLE_LSB +: 2] == typec_regs_pkg::ROLE_DUAL_PREF);
      state_nxt.acc_det   = ctrl_v[typec_regs_pkg::CTRL_ACC_DET];
      state_nxt.role      = ctrl_v[typec_regs_pkg::CTRL_ROLE_LSB +: 2];
      if (ctrl_v[typec_regs_pkg::CTRL_ROLE_LSB +: 2] == typec_regs_pkg::ROLE_SINK || sink_s) begin
         state_nxt.cur = typec_regs_pkg::CUR_DEFAULT;
      end else begin
         state_nxt.cur = ctrl_v[typec_regs_pkg::CTRL_CUR_LSB +: 2];
      end

      // interrupt pin: low while unmasked latched bits stand and power saving is off
      // the live fault bit lies outside the latched set and never drives it
      any_ev = |(state_nxt.flags & typec_regs_pkg::FLAGS_LATCHED);
      state_nxt.int_oe_n = ~(any_ev & ~ctrl_v[typec_regs_pkg::CTRL_MASK] &
                             ~ctrl_v[typec_regs_pkg::CTRL_POWERSAVE]);
   end

   // state register
   // reset leaves the interrupt pin released
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         state_r          <= '0;
         state_r.ctrl     <= typec_regs_pkg::CTRL_RESET;
         state_r.flags    <= typec_regs_pkg::FLAGS_RESET;
         state_r.int_oe_n <= 1'b1;
      end else if (ce_in) begin
         state_r <= state_nxt;
      end
   end

   // outputs straight from the state flops
   assign reg_rdata_out                = state_r.rdata;
   assign low_power_out                = state_r.low_power;
   assign outputs_hiz_out              = state_r.hiz;
   assign cc_pulldown_out              = state_r.cc_pd;
   assign prefer_source_attempt_out    = state_r.pref_src;
   assign prefer_sink_attempt_out      = state_r.pref_snk;
   assign accessory_detect_en_out      = state_r.acc_det;
   assign source_current_out           = state_r.cur;
   assign port_role_out                = state_r.role;
   // open-drain pin: value fixed low, only the enable moves
   assign interrupt_request_n_out      = 1'b0;
   assign interrupt_request_n_oe_n_out = state_r.int_oe_n;
endmodule : typec_port_control_interrupt_regs
`default_nettype wire

// ### tb/typec_regs_asserts.sv
// assertions on the ports of the register bank
`timescale 1ns/100ps
`default_nettype none
module typec_regs_asserts (
   input wire logic       ref_clk_in,
   input wire logic       sys_rst_in,
   input wire logic       ce_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic       reg_wr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic       reg_rd_in,
   input wire logic       reg_rd_done_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic       low_power_out,
   input wire logic       outputs_hiz_out,
   input wire logic       cc_pulldown_out,
   input wire logic       prefer_source_attempt_out,
   input wire logic       prefer_sink_attempt_out,
   input wire logic       accessory_detect_en_out,
   input wire logic [1:0] source_current_out,
   input wire logic [1:0] port_role_out,
   input wire logic       interrupt_request_n_oe_n_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (sys_rst_in);
   // control write, and a masking write with no write behind it
   sequence ctrl_wr; ce_in && reg_wr_in && reg_addr_in == 8'h02; endsequence
   sequence mask_wr; ctrl_wr ##0 reg_wdata_in[0] ##1 ce_in && !reg_wr_in; endsequence
   a_power_save: assert property (ctrl_wr |=> low_power_out == $past(reg_wdata_in[7]))
      else $error("power saving bit not applied");
   a_float_pins: assert property (outputs_hiz_out == low_power_out && cc_pulldown_out == low_power_out)
      else $error("float or pull-down disagrees with power saving");
   a_accessory_bit: assert property (ctrl_wr |=> accessory_detect_en_out == $past(reg_wdata_in[5]))
      else $error("accessory detect bit not applied");
   a_pref_role: assert property (prefer_source_attempt_out || prefer_sink_attempt_out |->
      port_role_out == 2'h3 && !(prefer_source_attempt_out && prefer_sink_attempt_out)) else $error("bad preference");
   a_sink_current: assert property (port_role_out == 2'h0 |-> source_current_out == 2'h0)
      else $error("current level passed for sink role");
   a_mask_release: assert property (mask_wr |=> interrupt_request_n_oe_n_out)
      else $error("masked pin still driven");
   a_pin_holds: assert property (!interrupt_request_n_oe_n_out && !reg_rd_done_in && !reg_wr_in
      |=> !interrupt_request_n_oe_n_out) else $error("pin released without clearing read");
   a_rdata_stands: assert property (!(ce_in && reg_rd_in) |=> $stable(reg_rdata_out))
      else $error("read data changed without a read");
   a_unmapped_zero: assert property (ce_in && reg_rd_in && reg_addr_in[7:1] != 7'h01 |=> reg_rdata_out == 8'h00)
      else $error("unmapped read not zero");
endmodule : typec_regs_asserts
bind typec_port_control_interrupt_regs typec_regs_asserts chk_i (.*);
`default_nettype wire

// ### tb/host_reg_master.sv
// system processor model driving the register strobes
`timescale 1ns/100ps
`default_nettype none
module host_reg_master (
   input  wire logic       ref_clk_in,
   input  wire logic [7:0] reg_rdata_in,
   output var  logic [7:0] reg_addr_out = 8'h00,
   output var  logic       reg_wr_out = 1'h0,
   output var  logic [7:0] reg_wdata_out = 8'h00,
   output var  logic       reg_rd_out = 1'h0,
   output var  logic       reg_rd_done_out = 1'h0
);
   // one write strobe taken at one edge, stale data inverted after
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk_in);
      reg_addr_out  <= a;
      reg_wdata_out <= d;
      reg_wr_out    <= 1'h1;
      @(posedge ref_clk_in);
      reg_wr_out    <= 1'h0;
      reg_wdata_out <= ~d;
   endtask : write_reg
   // read strobe, then byte delivered with the done pulse
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk_in);
      reg_addr_out    <= a;
      reg_rd_out      <= 1'h1;
      @(posedge ref_clk_in);
      reg_rd_out      <= 1'h0;
      reg_rd_done_out <= 1'h1;
      @(posedge ref_clk_in);
      d = reg_rdata_in;
      reg_rd_done_out <= 1'h0;
   endtask : read_reg
endmodule : host_reg_master
`default_nettype wire

// ### tb/typec_port_control_interrupt_regs_tb.sv
// self-checking bench for the control and event flag registers
`timescale 1ns/100ps
`default_nettype none
module typec_port_control_interrupt_regs_tb;
   logic       ref_clk_in = 1'h0, sys_rst_in = 1'h1, ce_in = 1'h1, chip_enable_n_in = 1'h1;
   logic       fault_live_in = 1'h0, attached_in = 1'h0, acting_as_sink_in = 1'h0;
   logic [1:0] role_strap_in = 2'h2, source_current_out, port_role_out;
   logic [3:0] ev = 4'h0; // recovered, over-current, over-voltage, over-temperature
   wire        fault_recovered_in = ev[3], over_current_event_in = ev[2];
   wire        over_voltage_event_in = ev[1], over_temp_event_in = ev[0];
   wire  [7:0] reg_addr_in, reg_wdata_in;
   wire        reg_wr_in, reg_rd_in, reg_rd_done_in;
   logic [7:0] reg_rdata_out, c, got;
   logic       low_power_out, outputs_hiz_out, cc_pulldown_out, prefer_source_attempt_out;
   logic       prefer_sink_attempt_out, accessory_detect_en_out, interrupt_request_n_out;
   logic       interrupt_request_n_oe_n_out;
   int         fail_count = 0, samples_checked = 0, seed = 32'h994D67E8;
   logic [7:0] ftab [6] = '{8'h80, 8'h40, 8'h20, 8'h08, 8'h01, 8'h02};
   typec_port_control_interrupt_regs DUT (.*);
   host_reg_master host (.ref_clk_in, .reg_rdata_in(reg_rdata_out), .reg_addr_out(reg_addr_in),
      .reg_wr_out(reg_wr_in), .reg_wdata_out(reg_wdata_in), .reg_rd_out(reg_rd_in), .reg_rd_done_out(reg_rd_done_in));
   always #2.5 ref_clk_in = ~ref_clk_in;
   // expected settings outputs packed like the control byte
   function automatic logic [7:0] exp_out(input logic [7:0] v, input logic snk);
      logic p;
      p = (v[2:1] == 2'h3);
      return {v[7], p & v[6], v[5], (v[2:1] != 2'h0 && !snk) ? v[4:3] : 2'h0, v[2:1], p & !v[6]};
   endfunction : exp_out
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // event i: four pulses, then attach rise and fall
   task automatic fire(input int i);
      @(posedge ref_clk_in);
      if (i < 4) ev[3-i] <= 1'h1;
      else attached_in <= (i == 4);
      repeat (3) @(posedge ref_clk_in);
      ev <= 4'h0;
      repeat (4) @(posedge ref_clk_in);
   endtask : fire
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : tally_and_finish
   // watchdog against a hang
   initial begin
      #50000;
      fail_count++;
      tally_and_finish();
   end
   // reset, strap, settings, events
   initial begin
      repeat (2) @(posedge ref_clk_in);
      sys_rst_in <= 1'h0;
      host.read_reg(8'h03, got);
      chk("flags reset", 8'h00, got);
      chip_enable_n_in <= 1'h0;
      repeat (6) @(posedge ref_clk_in);
      chk("strap role", 8'h02, {6'h0, port_role_out});
      role_strap_in <= 2'h1;
      chip_enable_n_in <= 1'h1;
      repeat (6) @(posedge ref_clk_in);
      chip_enable_n_in <= 1'h0;
      repeat (6) @(posedge ref_clk_in);
      chk("strap once", 8'h02, {6'h0, port_role_out});
      for (int k = 0; k < 48; k++) begin
         c = (k < 32) ? {1'h0, k[4], k[2], k[3:2], k[1:0], 1'h1} : 8'($random(seed));
         acting_as_sink_in <= (k < 32) ? k[2] ^ k[3] : 1'($random(seed));
         repeat (3) @(posedge ref_clk_in);
         host.write_reg(8'h02, c);
         @(posedge ref_clk_in);
         chk("settings", exp_out(c, acting_as_sink_in), {low_power_out, prefer_sink_attempt_out,
            accessory_detect_en_out, source_current_out, port_role_out, prefer_source_attempt_out});
         chk("float pins", {6'h0, c[7], c[7]}, {6'h0, outputs_hiz_out, cc_pulldown_out});
         host.read_reg(8'h02, got);
         chk("ctrl readback", c, got);
      end
      host.write_reg(8'h02, 8'h00);
      for (int i = 0; i < 6; i++) begin
         fault_live_in <= i[0];
         fire(i);
         chk("pin low", 8'h00, {7'h0, interrupt_request_n_oe_n_out});
         chk("pin level", 8'h00, {7'h0, interrupt_request_n_out});
         host.read_reg(8'h03, got);
         chk("flags", ftab[i] | {5'h0, i[0], 2'h0}, got);
         @(negedge ref_clk_in);
         chk("pin freed", 8'h01, {7'h0, interrupt_request_n_oe_n_out});
         host.read_reg(8'h03, got);
         chk("flags cleared", {5'h0, i[0], 2'h0}, got);
      end
      host.write_reg(8'h02, 8'h01);
      fire(1);
      chk("pin masked", 8'h01, {7'h0, interrupt_request_n_oe_n_out});
      // clock enable low: a write must leave no trace
      ce_in <= 1'h0;
      host.write_reg(8'h02, 8'h20);
      ce_in <= 1'h1;
      host.read_reg(8'h02, got);
      chk("frozen write", 8'h01, got);
      host.write_reg(8'h03, 8'hFF);
      host.read_reg(8'h03, got);
      chk("flags after write", 8'h44, got);
      host.read_reg(8'h05, got);
      chk("unmapped", 8'h00, got);
      host.read_reg(8'h03, got);
      chk("live kept", 8'h04, got);
      tally_and_finish();
   end
endmodule : typec_port_control_interrupt_regs_tb
`default_nettype wire
